// ---- dv/swu_scsi_model.sv ----
`timescale 1ns/1ps
module swu_scsi_model (
   // clock
   input  wire logic clk_sys,
   // bus view driven by the far devices
   output logic      scsiBsy,
   output logic      scsiSel,
   output logic      discMsgSeen,
   output logic      selectedNow,
   output logic      reselectedNow,
   output logic      busIntEvt
);
   initial begin
      scsiBsy       = 1'b1;
      scsiSel       = 1'b0;
      discMsgSeen   = 1'b0;
      selectedNow   = 1'b0;
      reselectedNow = 1'b0;
      busIntEvt     = 1'b0;
   end

   task automatic levels(input logic s, input logic r);
      @(posedge clk_sys);
      selectedNow   <= s;
      reselectedNow <= r;
   endtask : levels

   task automatic disconnect();
      @(posedge clk_sys);
      discMsgSeen <= 1'b1;
      @(posedge clk_sys);
      discMsgSeen <= 1'b0;
      scsiBsy     <= 1'b0;
      repeat (40) @(posedge clk_sys);
      // a short select glitch must restart the free count
      scsiSel <= 1'b1;
      @(posedge clk_sys);
      scsiSel <= 1'b0;
   endtask : disconnect

   task automatic reconnect();
      @(posedge clk_sys);
      scsiBsy <= 1'b1;
   endtask : reconnect

   task automatic pulse_int();
      @(posedge clk_sys);
      busIntEvt <= 1'b1;
      @(posedge clk_sys);
      busIntEvt <= 1'b0;
   endtask : pulse_int
endmodule : swu_scsi_model

// ---- dv/swu_wait_unit_bench.sv ----
`timescale 1ns/1ps
module swu_wait_unit_bench
   import swu_pkg::*;
;
   logic        clk_sys;
   logic        rst;
   logic        wbCyc;
   logic        wbStb;
   logic        wbWe;
   logic [7:0]  wbAdr;
   logic [3:0]  wbSel;
   logic [31:0] wbDatI;
   logic [31:0] wbDatO;
   logic        wbAck;
   wire logic   scsiBsy;
   wire logic   scsiSel;
   wire logic   discMsgSeen;
   wire logic   selectedNow;
   wire logic   reselectedNow;
   wire logic   busIntEvt;
   logic        targetMode;
   logic        fetchValid;
   logic [31:0] fetchAddr;
   logic        waitBusy;
   logic        irq;
   int          n_errors;
   int          compares;
   int          nFetch;
   logic [31:0] lastAddr;
   logic [31:0] rd;
   logic [31:0] expQ[$];

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   swu_wait_unit i_dut (.clk_sys(clk_sys), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
      .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck),
      .scsiBsy(scsiBsy), .scsiSel(scsiSel), .discMsgSeen(discMsgSeen), .selectedNow(selectedNow),
      .reselectedNow(reselectedNow), .busIntEvt(busIntEvt), .targetMode(targetMode),
      .fetchValid(fetchValid), .fetchAddr(fetchAddr), .waitBusy(waitBusy), .irq(irq));
   swu_scsi_model i_scsi (.clk_sys(clk_sys), .scsiBsy(scsiBsy), .scsiSel(scsiSel),
      .discMsgSeen(discMsgSeen), .selectedNow(selectedNow), .reselectedNow(reselectedNow),
      .busIntEvt(busIntEvt));

   // fetch pulses stand one cycle only
   always @(posedge clk_sys) begin
      if (fetchValid === 1'b1) begin
         nFetch   <= nFetch + 1;
         lastAddr <= fetchAddr;
         cmp_bit(expQ.size() != 0, 1'b1);
         if (expQ.size() != 0) cmp_word(fetchAddr, expQ.pop_front());
      end
   end

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t word got %h exp %h", $time, got, exp);
      end
   endtask : cmp_word

   task automatic cmp_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t bit got %b exp %b", $time, got, exp);
      end
   endtask : cmp_bit

   // no local limit: only the watchdog ends a hung bus wait
   task automatic wb_rw(input logic we, input logic [7:0] adr, input logic [31:0] d);
      @(posedge clk_sys);
      wbCyc  <= 1'b1;
      wbStb  <= 1'b1;
      wbWe   <= we;
      wbAdr  <= adr;
      wbSel  <= 4'hF;
      wbDatI <= d;
      do begin
         @(posedge clk_sys);
      end while (wbAck !== 1'b1);
      rd = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe  <= 1'b0;
   endtask : wb_rw

   // pre: {selected, reselected} before start; act: 0 none 1 disc 2 resel 3 sel 4 int 5 host
   task automatic run_wait(input logic [31:0] ins, input logic [1:0] pre, input int act,
                           input logic sg, input logic alt, input logic udc);
      logic [31:0] sv;
      logic [31:0] pc;
      logic [31:0] exp;
      int          n;
      int          f0;
      sv  = $urandom;
      pc  = $urandom & 32'hFFFF_FFFC;
      exp = !alt ? pc : (ins[REL_BIT] ? pc + {{8{sv[23]}}, sv[23:0]} : sv);
      if (!udc) expQ.push_back(exp);
      i_scsi.levels(pre[1], pre[0]);
      wb_rw(1'b1, OFS_EVT, 32'h0000_000F);
      wb_rw(1'b1, OFS_SAVE, sv);
      wb_rw(1'b1, OFS_PC, pc);
      wb_rw(1'b1, OFS_INSTR, ins);
      wb_rw(1'b1, OFS_INTST, 32'(sg) << HSIG_BIT);
      f0 = nFetch;
      wb_rw(1'b1, OFS_EXEC, 32'h0000_0001);
      if (act != 0) begin
         repeat (3) @(posedge clk_sys);
         cmp_bit(waitBusy, 1'b1);
         cmp_word(32'(nFetch - f0), 32'h0);
         // pointer writes are refused while the wait stands
         wb_rw(1'b1, OFS_SAVE, ~sv);
         if (act == 1) i_scsi.disconnect();
         else if (act == 2) i_scsi.levels(1'b0, 1'b1);
         else if (act == 3) i_scsi.levels(1'b1, 1'b0);
         else if (act == 4) i_scsi.pulse_int();
         else wb_rw(1'b1, OFS_INTST, 32'h1 << HSIG_BIT);
      end else begin
         repeat (4) @(posedge clk_sys);
      end
      n = 0;
      while (waitBusy !== 1'b0 && n < 400) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 400) cmp_bit(waitBusy, 1'b0);
      if (act == 1) cmp_bit(n >= BUS_FREE_CYC - 1 && n <= BUS_FREE_CYC + 4, 1'b1);
      repeat (2) @(posedge clk_sys);
      cmp_word(32'(nFetch - f0), udc ? 32'h0 : 32'h1);
      if (!udc) cmp_word(lastAddr, exp);
      cmp_word(32'(expQ.size()), 32'h0);
      wb_rw(1'b0, OFS_EVT, 32'h0);
      cmp_word(rd & 32'h0000_000D, {28'h0, alt, 2'b00, udc});
      if (!alt && !udc) cmp_bit(rd[EV_DONE], 1'b1);
      cmp_bit(irq, alt | udc);
      if (act == 1) begin
         wb_rw(1'b0, OFS_STATE, 32'h0);
         cmp_bit(rd[4], 1'b1);
      end
      wb_rw(1'b1, OFS_EVT, 32'h0000_000F);
      wb_rw(1'b1, OFS_INTST, 32'h0);
      i_scsi.levels(1'b0, 1'b0);
      if (act == 1) i_scsi.reconnect();
      @(posedge clk_sys);
      cmp_bit(irq, 1'b0);
   endtask : run_wait

   task automatic conclude();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : conclude

   initial begin
      #500000;
      n_errors++;
      conclude();
   end

   initial begin
      n_errors = 0;
      compares = 0;
      nFetch   = 0;
      lastAddr = 32'h0;
      rst      = 1'b1;
      wbCyc    = 1'b0;
      wbStb    = 1'b0;
      wbWe     = 1'b0;
      wbAdr    = 8'h00;
      wbSel    = 4'hF;
      wbDatI   = 32'h0;
      void'($urandom(32'hFFEAA3D9));
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      cmp_word({28'h0, irq, waitBusy, targetMode, fetchValid}, RST_WORD);
      for (int a = 0; a <= 36; a += 4) begin
         wb_rw(1'b0, 8'(a), 32'h0);
         cmp_word(rd, RST_WORD);
      end
      wb_rw(1'b1, OFS_MASK, 32'h0000_0009);
      wb_rw(1'b0, OFS_MASK, 32'h0);
      cmp_word(rd, 32'h0000_0009);
      run_wait(32'h4C00_0000, 2'b00, 1, 1'b0, 1'b0, 1'b0);
      wb_rw(1'b1, OFS_CTL2, 32'h1 << UDC_BIT);
      run_wait(32'h4800_0000, 2'b00, 1, 1'b0, 1'b0, 1'b1);
      wb_rw(1'b1, OFS_CTL2, 32'h0);
      run_wait(32'h5000_0200, 2'b10, 0, 1'b0, 1'b0, 1'b0);
      cmp_bit(targetMode, 1'b1);
      run_wait(32'h5000_0200, 2'b00, 2, 1'b0, 1'b1, 1'b0);
      cmp_bit(targetMode, 1'b0);
      run_wait(32'h5400_0200, 2'b00, 4, 1'b0, 1'b1, 1'b0);
      run_wait(32'h5000_0000, 2'b00, 2, 1'b0, 1'b0, 1'b0);
      cmp_bit(targetMode, 1'b0);
      run_wait(32'h5000_0000, 2'b01, 0, 1'b0, 1'b0, 1'b0);
      run_wait(32'h5400_0000, 2'b01, 0, 1'b1, 1'b1, 1'b0);
      run_wait(32'h5400_0200, 2'b00, 5, 1'b0, 1'b1, 1'b0);
      run_wait(32'h5000_0000, 2'b00, 5, 1'b0, 1'b1, 1'b0);
      run_wait(32'h5000_0000, 2'b00, 3, 1'b0, 1'b1, 1'b0);
      for (int k = 0; k < 3; k++) begin
         wb_rw(1'b1, OFS_INSTR, k == 0 ? 32'h8800_0000 : (k == 1 ? 32'hC800_0000 : 32'h4000_0000));
         wb_rw(1'b1, OFS_EXEC, 32'h0000_0001);
         repeat (4) @(posedge clk_sys);
         cmp_bit(waitBusy, 1'b0);
         wb_rw(1'b0, OFS_EVT, 32'h0);
         cmp_bit(rd[EV_ILLEGAL], 1'b1);
         wb_rw(1'b1, OFS_EVT, 32'h0000_000F);
      end
      conclude();
   end
endmodule : swu_wait_unit_bench

// ---- logic/swu_dec_if.sv ----
`timescale 1ns/1ps
interface swu_dec_if;
   logic [31:0] instr;
   logic        isIo;
   logic        isWaitDisc;
   logic        isWaitSel;
   logic        isWaitResel;
   logic        relMode;
   logic        targetRole;

   modport dec (
      input  instr,
      output isIo, isWaitDisc, isWaitSel, isWaitResel, relMode, targetRole
   );
   modport use_side (
      output instr,
      input  isIo, isWaitDisc, isWaitSel, isWaitResel, relMode, targetRole
   );
endinterface : swu_dec_if

// ---- logic/swu_decode.sv ----
`timescale 1ns/1ps
module swu_decode
   import swu_pkg::*;
(
   // decoded instruction
   swu_dec_if.dec dif
);

   wire [1:0] instrType = dif.instr[TYPE_HI:TYPE_LO];
   wire [2:0] opcode    = dif.instr[OPC_HI:OPC_LO];

   assign dif.isIo        = (instrType == TYPE_IO);
   assign dif.isWaitDisc  = dif.isIo && (opcode == OPC_WAITDISC);
   assign dif.isWaitSel   = dif.isIo && (opcode == OPC_WAITSEL) && dif.instr[TGT_BIT];
   assign dif.isWaitResel = dif.isIo && (opcode == OPC_WAITSEL) && !dif.instr[TGT_BIT];
   assign dif.relMode     = dif.instr[REL_BIT];
   assign dif.targetRole  = dif.instr[TGT_BIT];

endmodule : swu_decode

// ---- logic/swu_pkg.sv ----
package swu_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_INSTR  = 8'h00;
   localparam logic [7:0] OFS_SAVE   = 8'h04;
   localparam logic [7:0] OFS_PC     = 8'h08;
   localparam logic [7:0] OFS_CTL2   = 8'h0C;
   localparam logic [7:0] OFS_INTST  = 8'h10;
   localparam logic [7:0] OFS_EXEC   = 8'h14;
   localparam logic [7:0] OFS_EVT    = 8'h18;
   localparam logic [7:0] OFS_MASK   = 8'h1C;
   localparam logic [7:0] OFS_STATE  = 8'h20;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int TYPE_HI      = 31;
   localparam int TYPE_LO      = 30;
   localparam int OPC_HI       = 29;
   localparam int OPC_LO       = 27;
   localparam int REL_BIT      = 26;
   localparam int TGT_BIT      = 9;
   localparam int OFFSET_W     = 24;
   localparam int UDC_BIT      = 7;
   localparam int HSIG_BIT     = 5;
   localparam int EXEC_GO_BIT  = 0;

   // event status bits
   localparam int EV_UDC       = 0;
   localparam int EV_DONE      = 1;
   localparam int EV_ILLEGAL   = 2;
   localparam int EV_ALT       = 3;
   localparam int EV_W         = 4;

   // ----------------------------------------------------------------
   // instruction codes
   // ----------------------------------------------------------------
   localparam logic [1:0] TYPE_IO      = 2'h1;
   localparam logic [2:0] OPC_WAITDISC = 3'h1;
   localparam logic [2:0] OPC_WAITSEL  = 3'h2;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [31:0]     RST_WORD = 32'h0000_0000;
   localparam logic [7:0]      RST_BYTE = 8'h00;
   localparam logic [EV_W-1:0] RST_EVT  = 4'h0;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int         CLK_NS       = 10;
   localparam int         BUS_FREE_NS  = 1000;
   localparam int         BUS_FREE_CYC = (BUS_FREE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0] BUS_FREE_CNT = 8'(BUS_FREE_CYC);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DISC,
      ST_SEL,
      ST_RESEL
   } swu_state_e;

endpackage : swu_pkg

// ---- logic/swu_wait_unit.sv ----
//Contract
// - wait-disconnect suspends execution until a disconnect from the bus is seen.
// - legal disconnect: busy and select released bus-free time after a disconnect message.
// - disconnect with unexpected-disconnect enable clear: run next sequential instruction.
// - disconnect with that enable set: raise unexpected-disconnect interrupt instead.
// - wait-select waits to be selected; already selected means continue at once.
// - reselection or bus interrupt during wait-select: become initiator, jump alternate.
// - host signal bit abandons a pending select or reselect wait to alternate.
// - host signal bit is tested before the reselected condition.
// - relative mode adds the 24-bit offset to the program counter.
// - alternate operand is 32-bit absolute or 24-bit relative, held in save pointer.
// - role bit 9: one gives target mode, zero initiator mode.
// - wait-reselect waits for a target to reselect, then runs next instruction.
// - already reselected at wait-reselect start: fetch next instruction immediately.
// - selected during wait-reselect: jump to alternate address.
// - I/O class is recognised by 01 in the top two instruction bits.
`timescale 1ns/1ps
module swu_wait_unit
   import swu_pkg::*;
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // wishbone slave
   input  wire logic        wbCyc,
   input  wire logic        wbStb,
   input  wire logic        wbWe,
   input  wire logic [7:0]  wbAdr,
   input  wire logic [3:0]  wbSel,
   input  wire logic [31:0] wbDatI,
   output logic      [31:0] wbDatO,
   output logic             wbAck,
   // scsi bus view
   input  wire logic        scsiBsy,
   input  wire logic        scsiSel,
   input  wire logic        discMsgSeen,
   input  wire logic        selectedNow,
   input  wire logic        reselectedNow,
   input  wire logic        busIntEvt,
   // sequencer side
   output logic             targetMode,
   output logic             fetchValid,
   output logic      [31:0] fetchAddr,
   output logic             waitBusy,
   output logic             irq
);

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [31:0]     instrWord;
   logic [31:0]     savePtr;
   logic [31:0]     progCnt;
   logic [7:0]      ctl2;
   logic [7:0]      intStat;
   logic [EV_W-1:0] evtStatus;
   logic [EV_W-1:0] evtMask;
   swu_state_e      state;
   logic [7:0]      busFreeCnt;
   logic            msgSeen;
   logic            legalDisc;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   swu_dec_if decIf ();

   assign decIf.instr = instrWord;

   swu_decode uDec (
      .dif (decIf.dec)
   );

   function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] din,
                                              input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = din[i*8 +: 8];
         end
      end
      return res;
   endfunction : mergeBytes

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   wire busReq    = wbCyc && wbStb && !wbAck;
   wire wrReq     = busReq && wbWe;
   wire hitInstr  = (wbAdr == OFS_INSTR);
   wire hitSave   = (wbAdr == OFS_SAVE);
   wire hitPc     = (wbAdr == OFS_PC);
   wire hitCtl2   = (wbAdr == OFS_CTL2);
   wire hitIntSt  = (wbAdr == OFS_INTST);
   wire hitExec   = (wbAdr == OFS_EXEC);
   wire hitEvt    = (wbAdr == OFS_EVT);
   wire hitMask   = (wbAdr == OFS_MASK);
   wire hitState  = (wbAdr == OFS_STATE);

   wire [31:0] wrMerged = mergeBytes(32'h0000_0000, wbDatI, wbSel);
   wire        startReq = wrReq && hitExec && wbSel[0] && wbDatI[EXEC_GO_BIT] && (state == ST_IDLE);
   wire        udcEn    = ctl2[UDC_BIT];
   wire        hostSig  = intStat[HSIG_BIT];
   // busy regs are locked so software cannot move the operands under a wait
   wire        regsOpen = (state == ST_IDLE);

   wire [31:0] relTarget = progCnt + {{(32-OFFSET_W){savePtr[OFFSET_W-1]}}, savePtr[OFFSET_W-1:0]};
   wire [31:0] altAddr   = decIf.relMode ? relTarget : savePtr;

   wire [31:0] rdData =
      hitInstr ? instrWord :
      hitSave  ? savePtr :
      hitPc    ? progCnt :
      hitCtl2  ? {24'h000000, ctl2} :
      hitIntSt ? {24'h000000, intStat} :
      hitEvt   ? {28'h0000000, evtStatus} :
      hitMask  ? {28'h0000000, evtMask} :
      hitState ? {27'h0000000, legalDisc, msgSeen, waitBusy, targetMode, 1'b0} :
      32'h0000_0000;

   // ----------------------------------------------------------------
   // wait sequencer
   // ----------------------------------------------------------------
   swu_state_e      next_state;
   logic            next_targetMode;
   logic            finishSeq;
   logic            finishAlt;
   logic            raiseUdc;
   logic            illegalEvt;
   logic [EV_W-1:0] next_evtStatus;

   wire busFreeDone = (busFreeCnt >= BUS_FREE_CNT);

   always_comb begin
      next_state      = state;
      next_targetMode = targetMode;
      finishSeq       = 1'b0;
      finishAlt       = 1'b0;
      raiseUdc        = 1'b0;
      illegalEvt      = 1'b0;
      unique case (state)
         ST_IDLE: begin
            if (startReq) begin
               // disconnect wait never reads the second word
               if (decIf.isWaitDisc) begin
                  next_state = ST_DISC;
               end else if (decIf.isWaitSel) begin
                  next_targetMode = decIf.targetRole;
                  next_state      = ST_SEL;
               end else if (decIf.isWaitResel) begin
                  next_targetMode = decIf.targetRole;
                  next_state      = ST_RESEL;
               end else begin
                  illegalEvt = 1'b1;
               end
            end
         end
         ST_DISC: begin
            if (busFreeDone) begin
               next_state = ST_IDLE;
               if (udcEn) begin
                  raiseUdc = 1'b1;
               end else begin
                  finishSeq = 1'b1;
               end
            end
         end
         ST_SEL: begin
            if (hostSig) begin
               finishAlt  = 1'b1;
               next_state = ST_IDLE;
            end else if (reselectedNow || busIntEvt) begin
               finishAlt       = 1'b1;
               next_targetMode = 1'b0;
               next_state      = ST_IDLE;
            end else if (selectedNow) begin
               finishSeq  = 1'b1;
               next_state = ST_IDLE;
            end
         end
         ST_RESEL: begin
            if (hostSig) begin
               finishAlt  = 1'b1;
               next_state = ST_IDLE;
            end else if (reselectedNow) begin
               finishSeq  = 1'b1;
               next_state = ST_IDLE;
            end else if (selectedNow) begin
               finishAlt  = 1'b1;
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // sticky events; a new event wins over a same-cycle clear
   wire [EV_W-1:0] evtSet = {finishAlt, illegalEvt, finishSeq | finishAlt, raiseUdc};
   wire [EV_W-1:0] evtClr = (wrReq && hitEvt && wbSel[0]) ? wbDatI[EV_W-1:0] : RST_EVT;

   always_comb begin
      next_evtStatus = (evtStatus & ~evtClr) | evtSet;
   end

   // ----------------------------------------------------------------
   // flops
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wbAck  <= 1'b0;
         wbDatO <= RST_WORD;
      end else begin
         wbAck  <= busReq;
         wbDatO <= busReq ? rdData : RST_WORD;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         instrWord <= RST_WORD;
         savePtr   <= RST_WORD;
         ctl2      <= RST_BYTE;
         intStat   <= RST_BYTE;
         evtMask   <= RST_EVT;
      end else if (wrReq) begin
         if (hitInstr && regsOpen) instrWord <= mergeBytes(instrWord, wbDatI, wbSel);
         if (hitSave && regsOpen)  savePtr <= mergeBytes(savePtr, wbDatI, wbSel);
         if (hitCtl2 && wbSel[0])  ctl2 <= wrMerged[7:0];
         if (hitIntSt && wbSel[0]) intStat <= wrMerged[7:0];
         if (hitMask && wbSel[0])  evtMask <= wrMerged[EV_W-1:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         progCnt <= RST_WORD;
      end else if (finishAlt) begin
         progCnt <= altAddr;
      end else if (wrReq && hitPc && regsOpen) begin
         progCnt <= mergeBytes(progCnt, wbDatI, wbSel);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state      <= ST_IDLE;
         targetMode <= 1'b0;
         fetchValid <= 1'b0;
         fetchAddr  <= RST_WORD;
         waitBusy   <= 1'b0;
         evtStatus  <= RST_EVT;
         irq        <= 1'b0;
      end else begin
         state      <= next_state;
         targetMode <= next_targetMode;
         fetchValid <= finishSeq || finishAlt;
         if (finishSeq || finishAlt) fetchAddr <= finishAlt ? altAddr : progCnt;
         waitBusy   <= (next_state != ST_IDLE);
         evtStatus  <= next_evtStatus;
         irq        <= |(next_evtStatus & evtMask);
      end
   end

   // disconnect watch: a message arms legality, any busy or select restarts the clock
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         busFreeCnt <= 8'h00;
         msgSeen    <= 1'b0;
         legalDisc  <= 1'b0;
      end else if (state != ST_DISC) begin
         busFreeCnt <= 8'h00;
         msgSeen    <= 1'b0;
      end else begin
         if (scsiBsy || scsiSel) busFreeCnt <= 8'h00;
         else if (!busFreeDone)  busFreeCnt <= busFreeCnt + 8'h01;
         if (discMsgSeen) msgSeen <= 1'b1;
         if (busFreeDone) legalDisc <= msgSeen;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   AST_DISC_HOLD: assert property (
      (state == ST_DISC) && !busFreeDone |=> !fetchValid)
      else $error("disconnect wait released early");
   AST_BUS_FREE: assert property (
      (state == ST_DISC) && (scsiBsy || scsiSel) |=> (busFreeCnt == 8'h00))
      else $error("bus free count not restarted");
   AST_DISC_SEQ: assert property (
      (state == ST_DISC) && busFreeDone && !udcEn |=> fetchValid && (fetchAddr == $past(progCnt)))
      else $error("disconnect did not continue sequentially");
   AST_DISC_UDC: assert property (
      (state == ST_DISC) && busFreeDone && udcEn |=> evtStatus[EV_UDC] && !fetchValid && !waitBusy)
      else $error("unexpected disconnect not raised");
   AST_SEL_SELD: assert property (
      (state == ST_SEL) && !hostSig && !reselectedNow && !busIntEvt && selectedNow
      |=> fetchValid && (fetchAddr == $past(progCnt)))
      else $error("selection did not continue");
   AST_SEL_RESEL: assert property (
      (state == ST_SEL) && !hostSig && (reselectedNow || busIntEvt)
      |=> !targetMode && fetchValid && (fetchAddr == $past(altAddr)))
      else $error("reselect during select wait mishandled");
   AST_HOST_ALT: assert property (
      ((state == ST_SEL) || (state == ST_RESEL)) && hostSig
      |=> fetchValid && (fetchAddr == $past(altAddr)) && !waitBusy)
      else $error("host signal not given priority");
   AST_REL_ADDR: assert property (
      (state == ST_RESEL) && hostSig && decIf.relMode
      |=> fetchAddr == $past(progCnt) + {{8{$past(savePtr[23])}}, $past(savePtr[23:0])})
      else $error("relative target wrong");
   AST_ROLE: assert property (
      startReq && decIf.isWaitSel |=> targetMode && (state == ST_SEL))
      else $error("target role not taken");
   AST_RESEL_OK: assert property (
      (state == ST_RESEL) && !hostSig && reselectedNow |=> fetchValid && (fetchAddr == $past(progCnt)))
      else $error("reselection did not continue");
   AST_RESEL_SELD: assert property (
      (state == ST_RESEL) && !hostSig && !reselectedNow && selectedNow
      |=> fetchValid && (fetchAddr == $past(altAddr)))
      else $error("selection in reselect wait not diverted");
   AST_ILLEGAL: assert property (
      startReq && !decIf.isIo |=> evtStatus[EV_ILLEGAL] && (state == ST_IDLE))
      else $error("non I/O instruction accepted");

endmodule : swu_wait_unit
